// File: logic/cpu16_pkg.sv
package cpu16_pkg;

  // ****************************************************************
  // Widths and reset values.
  // ****************************************************************
  localparam int ADDR_W = 16;
  localparam int DATA_W = 16;
  localparam int NUM_GPR = 6;
  localparam int AXI_ADDR_W = 8;
  localparam logic [15:0] RESET_PC = 16'h0000;
  localparam logic [15:0] RESERVED_LOC = 16'h0301;
  localparam logic [15:0] PC_STEP = 16'h0001;
  localparam logic [15:0] PC_STEP_OPND = 16'h0002;

  // ****************************************************************
  // Instruction fields.
  // ****************************************************************
  localparam int OPC_LSB = 0;
  localparam int SET_LSB = 4;
  localparam int R1_LSB = 7;
  localparam int R2_LSB = 10;
  localparam int RO_LSB = 13;
  localparam int LREG_LSB = 5;
  localparam int LIT_LSB = 8;
  localparam logic [2:0] REG_ZERO = 3'h0;
  localparam logic [2:0] REG_FLAGS = 3'h7;

  localparam logic [3:0] OP_NOP = 4'h0;
  localparam logic [3:0] OP_ALU = 4'h1;
  localparam logic [3:0] OP_ALUI = 4'h2;
  localparam logic [3:0] OP_JMP = 4'h4;
  localparam logic [3:0] OP_LOAD = 4'h5;
  localparam logic [3:0] OP_STORE = 4'h6;

  localparam logic [2:0] ALU_ADD = 3'h0;
  localparam logic [2:0] ALU_SUB = 3'h1;
  localparam logic [2:0] ALU_MUL = 3'h2;
  localparam logic [2:0] ALU_NAND = 3'h3;

  localparam logic [2:0] JMP_ALWAYS = 3'h0;
  localparam logic [2:0] JMP_ZERO = 3'h1;
  localparam logic [2:0] JMP_GREATER = 3'h2;
  localparam logic [2:0] JMP_LESS = 3'h3;
  localparam logic [2:0] JMP_MEM = 3'h4;
  localparam logic [2:0] JMP_SERIAL = 3'h5;
  localparam logic [2:0] JMP_IMM = 3'h6;
  localparam logic [2:0] JMP_EQUAL = 3'h7;

  // ****************************************************************
  // Software registers.
  // ****************************************************************
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_PC = 8'h08;
  localparam logic [7:0] REG_INSTR = 8'h0c;
  localparam logic [7:0] REG_GPR_BASE = 8'h20;
  localparam logic CTRL_RUN_RESET = 1'b1;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ****************************************************************
  // Types.
  // ****************************************************************
  typedef enum {
    ST_IDLE,
    ST_FETCH,
    ST_DECODE,
    ST_OPERAND,
    ST_DATA
  } cpu16_state_e;

  typedef struct packed {
    logic valid;
    logic write;
    logic [15:0] addr;
    logic [15:0] wdata;
  } cpu16_mem_req_s;

  typedef struct packed {
    logic ack;
    logic [15:0] rdata;
  } cpu16_mem_rsp_s;

  typedef struct packed {
    logic serial_port_flag;
    logic memory_flag;
    logic equal_flag;
    logic greater_flag;
    logic zero_flag;
  } cpu16_flags_s;

endpackage

// File: logic/cpu16_core.sv
`timescale 1ns/1ps

module cpu16_core (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [cpu16_pkg::AXI_ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [cpu16_pkg::AXI_ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output cpu16_pkg::cpu16_mem_req_s mem_req,
  input cpu16_pkg::cpu16_mem_rsp_s mem_rsp,
  input wire logic memory_flag_pin,
  input wire logic serial_port_flag_pin
);

  // ****************************************************************
  // State.
  // ****************************************************************
  cpu16_pkg::cpu16_state_e state_q;
  cpu16_pkg::cpu16_mem_req_s mem_q;
  cpu16_pkg::cpu16_flags_s flags_q;
  logic [15:0] pc_q;
  logic [15:0] instr_q;
  logic [15:0] gpr_q [1:cpu16_pkg::NUM_GPR];
  logic [1:0] pin_meta_q;
  logic [1:0] pin_sync_q;
  logic run_q;
  logic wb_en;
  logic [2:0] wb_idx;
  logic [15:0] wb_data;
  logic [15:0] alu_res;
  logic [15:0] op_a;
  logic [15:0] op_b;
  logic take_jump;

  wire logic [3:0] opc = instr_q[cpu16_pkg::OPC_LSB +: 4];
  wire logic [2:0] sets = instr_q[cpu16_pkg::SET_LSB +: 3];
  wire logic [2:0] r1_idx = instr_q[cpu16_pkg::R1_LSB +: 3];
  wire logic [2:0] r2_idx = instr_q[cpu16_pkg::R2_LSB +: 3];
  wire logic [2:0] ro_idx = instr_q[cpu16_pkg::RO_LSB +: 3];
  wire logic [2:0] lreg_idx = instr_q[cpu16_pkg::LREG_LSB +: 3];
  wire logic [7:0] lit_byte = instr_q[cpu16_pkg::LIT_LSB +: 8];

  function automatic logic [15:0] reg_rd(input logic [2:0] idx);
    logic [15:0] v;
    v = 16'h0000;
    if (idx == cpu16_pkg::REG_FLAGS) begin
      v = {11'h000, flags_q};
    end else if (idx != cpu16_pkg::REG_ZERO) begin
      v = gpr_q[idx];
    end
    return v;
  endfunction

  logic [15:0] r1_val, r2_val, lreg_val;

  // ****************************************************************
  // Flag pin synchronisers.
  // ****************************************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_meta_q <= 2'h0;
      pin_sync_q <= 2'h0;
    end else begin
      pin_meta_q <= {serial_port_flag_pin, memory_flag_pin};
      pin_sync_q <= pin_meta_q;
    end
  end

  // ****************************************************************
  // Arithmetic.
  // ****************************************************************
  always_comb begin
    r1_val = reg_rd(r1_idx);
    r2_val = reg_rd(r2_idx);
    lreg_val = reg_rd(lreg_idx);
    op_a = r1_val;
    op_b = r2_val;
    alu_res = 16'h0000;
    if (opc == cpu16_pkg::OP_ALUI) begin
      op_a = lreg_val;
      op_b = {8'h00, lit_byte};
      if (sets[0]) begin
        alu_res = lreg_val * {8'h00, lit_byte};
      end else begin
        alu_res = lreg_val + {8'h00, lit_byte};
      end
    end else begin
      unique case (sets)
        cpu16_pkg::ALU_ADD: alu_res = r1_val + r2_val;
        cpu16_pkg::ALU_SUB: alu_res = r1_val - r2_val;
        cpu16_pkg::ALU_MUL:
          alu_res = {8'h00, r1_val[7:0]} * {8'h00, r2_val[7:0]};
        cpu16_pkg::ALU_NAND: alu_res = ~(r1_val & r2_val);
        default: alu_res = 16'h0000;
      endcase
    end
  end

  always_comb begin
    unique case (sets)
      cpu16_pkg::JMP_ALWAYS: take_jump = 1'b1;
      cpu16_pkg::JMP_ZERO: take_jump = flags_q.zero_flag;
      cpu16_pkg::JMP_GREATER: take_jump = flags_q.greater_flag;
      cpu16_pkg::JMP_LESS: take_jump = !flags_q.greater_flag;
      cpu16_pkg::JMP_MEM: take_jump = flags_q.memory_flag;
      cpu16_pkg::JMP_SERIAL: take_jump = flags_q.serial_port_flag;
      cpu16_pkg::JMP_EQUAL: take_jump = flags_q.equal_flag;
      default: take_jump = 1'b0;
    endcase
  end

  // ****************************************************************
  // Register write back.
  // ****************************************************************
  always_comb begin
    wb_en = 1'b0;
    wb_idx = ro_idx;
    wb_data = alu_res;
    if (state_q == cpu16_pkg::ST_DECODE) begin
      if (opc == cpu16_pkg::OP_ALU && !sets[2]) begin
        wb_en = 1'b1;
      end else if (opc == cpu16_pkg::OP_ALUI) begin
        wb_en = 1'b1;
        wb_idx = lreg_idx;
      end else if (opc == cpu16_pkg::OP_JMP &&
                   sets != cpu16_pkg::JMP_ALWAYS &&
                   sets != cpu16_pkg::JMP_IMM) begin
        wb_en = 1'b1;
        wb_data = pc_q;
      end
    end else if (state_q == cpu16_pkg::ST_DATA && mem_rsp.ack &&
                 opc == cpu16_pkg::OP_LOAD) begin
      wb_en = 1'b1;
      wb_data = mem_rsp.rdata;
    end
  end

  for (genvar i = 1; i <= cpu16_pkg::NUM_GPR; i++) begin : g_gpr
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        gpr_q[i] <= 16'h0000;
      end else if (wb_en && wb_idx == 3'(i)) begin
        gpr_q[i] <= wb_data;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      flags_q <= '0;
    end else begin
      flags_q.memory_flag <= pin_sync_q[0];
      flags_q.serial_port_flag <= pin_sync_q[1];
      if (state_q == cpu16_pkg::ST_DECODE &&
          ((opc == cpu16_pkg::OP_ALU && !sets[2]) ||
           opc == cpu16_pkg::OP_ALUI)) begin
        flags_q.zero_flag <= (alu_res == 16'h0000);
        flags_q.greater_flag <= (op_a > op_b);
        flags_q.equal_flag <= (op_a == op_b);
      end
    end
  end

  // ****************************************************************
  // Sequencer.
  // ****************************************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_q <= cpu16_pkg::ST_IDLE;
      pc_q <= cpu16_pkg::RESET_PC;
      instr_q <= 16'h0000;
      mem_q <= '0;
    end else begin
      unique case (state_q)
        cpu16_pkg::ST_IDLE: begin
          if (run_q) begin
            mem_q <= '{valid: 1'b1, write: 1'b0, addr: pc_q,
                       wdata: 16'h0000};
            state_q <= cpu16_pkg::ST_FETCH;
          end
        end
        cpu16_pkg::ST_FETCH: begin
          if (mem_rsp.ack) begin
            mem_q.valid <= 1'b0;
            instr_q <= mem_rsp.rdata;
            state_q <= cpu16_pkg::ST_DECODE;
          end
        end
        cpu16_pkg::ST_DECODE: begin
          state_q <= cpu16_pkg::ST_IDLE;
          pc_q <= pc_q + cpu16_pkg::PC_STEP;
          unique case (opc)
            cpu16_pkg::OP_JMP: begin
              if (sets == cpu16_pkg::JMP_IMM) begin
                mem_q <= '{valid: 1'b1, write: 1'b0,
                           addr: pc_q + cpu16_pkg::PC_STEP,
                           wdata: 16'h0000};
                pc_q <= pc_q;
                state_q <= cpu16_pkg::ST_OPERAND;
              end else if (take_jump) begin
                pc_q <= r1_val;
              end
            end
            cpu16_pkg::OP_LOAD, cpu16_pkg::OP_STORE: begin
              pc_q <= pc_q;
              if (sets[0]) begin
                mem_q <= '{valid: 1'b1,
                           write: opc == cpu16_pkg::OP_STORE,
                           addr: r1_val, wdata: r2_val};
                state_q <= cpu16_pkg::ST_DATA;
              end else begin
                mem_q <= '{valid: 1'b1, write: 1'b0,
                           addr: pc_q + cpu16_pkg::PC_STEP,
                           wdata: 16'h0000};
                state_q <= cpu16_pkg::ST_OPERAND;
              end
            end
            default: ;
          endcase
        end
        cpu16_pkg::ST_OPERAND: begin
          if (mem_rsp.ack) begin
            if (opc == cpu16_pkg::OP_JMP) begin
              mem_q.valid <= 1'b0;
              pc_q <= mem_rsp.rdata;
              state_q <= cpu16_pkg::ST_IDLE;
            end else begin
              mem_q <= '{valid: 1'b1,
                         write: opc == cpu16_pkg::OP_STORE,
                         addr: mem_rsp.rdata, wdata: r2_val};
              state_q <= cpu16_pkg::ST_DATA;
            end
          end
        end
        cpu16_pkg::ST_DATA: begin
          if (mem_rsp.ack) begin
            mem_q.valid <= 1'b0;
            pc_q <= pc_q + (sets[0] ? cpu16_pkg::PC_STEP :
                            cpu16_pkg::PC_STEP_OPND);
            state_q <= cpu16_pkg::ST_IDLE;
          end
        end
      endcase
    end
  end

  assign mem_req = mem_q;

  // ****************************************************************
  // Register bus write channel.
  // ****************************************************************
  logic aw_pend_q;
  logic w_pend_q;
  logic awready_q;
  logic wready_q;
  logic bvalid_q;
  logic [1:0] bresp_q;
  logic [7:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;

  wire logic aw_take = s_axi_awvalid & awready_q;
  wire logic w_take = s_axi_wvalid & wready_q;
  wire logic wr_go = aw_pend_q & w_pend_q & ~bvalid_q;
  wire logic aw_pend_d = (aw_pend_q & ~wr_go) | aw_take;
  wire logic w_pend_d = (w_pend_q & ~wr_go) | w_take;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_pend_q <= 1'b0;
      w_pend_q <= 1'b0;
      awready_q <= 1'b0;
      wready_q <= 1'b0;
      bvalid_q <= 1'b0;
      bresp_q <= cpu16_pkg::RESP_OKAY;
      awaddr_q <= 8'h00;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
    end else begin
      aw_pend_q <= aw_pend_d;
      w_pend_q <= w_pend_d;
      awready_q <= ~aw_pend_d;
      wready_q <= ~w_pend_d;
      if (aw_take) begin
        awaddr_q <= s_axi_awaddr;
      end
      if (w_take) begin
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end
      if (wr_go) begin
        bvalid_q <= 1'b1;
        bresp_q <= (awaddr_q == cpu16_pkg::REG_CTRL) ?
                   cpu16_pkg::RESP_OKAY : cpu16_pkg::RESP_SLVERR;
      end else if (bvalid_q && s_axi_bready) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      run_q <= cpu16_pkg::CTRL_RUN_RESET;
    end else if (wr_go && awaddr_q == cpu16_pkg::REG_CTRL &&
                 wstrb_q[0]) begin
      run_q <= wdata_q[0];
    end
  end

  // ****************************************************************
  // Register bus read channel.
  // ****************************************************************
  logic arready_q;
  logic rvalid_q;
  logic [1:0] rresp_q;
  logic [31:0] rdata_q;
  logic [31:0] rd_data;
  logic rd_ok;

  always_comb begin
    rd_ok = 1'b1;
    rd_data = 32'h0000_0000;
    if (s_axi_araddr == cpu16_pkg::REG_CTRL) begin
      rd_data = {31'h0000_0000, run_q};
    end else if (s_axi_araddr == cpu16_pkg::REG_STATUS) begin
      rd_data = {26'h000_0000, state_q != cpu16_pkg::ST_IDLE, flags_q};
    end else if (s_axi_araddr == cpu16_pkg::REG_PC) begin
      rd_data = {16'h0000, pc_q};
    end else if (s_axi_araddr == cpu16_pkg::REG_INSTR) begin
      rd_data = {16'h0000, instr_q};
    end else if (s_axi_araddr[7:5] == cpu16_pkg::REG_GPR_BASE[7:5] &&
                 s_axi_araddr[1:0] == 2'h0) begin
      rd_data = {16'h0000, reg_rd(s_axi_araddr[4:2])};
    end else begin
      rd_ok = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_q <= 1'b0;
      rvalid_q <= 1'b0;
      rresp_q <= cpu16_pkg::RESP_OKAY;
      rdata_q <= 32'h0000_0000;
    end else if (s_axi_arvalid && arready_q) begin
      arready_q <= 1'b0;
      rvalid_q <= 1'b1;
      rdata_q <= rd_data;
      rresp_q <= rd_ok ? cpu16_pkg::RESP_OKAY : cpu16_pkg::RESP_SLVERR;
    end else if (rvalid_q && s_axi_rready) begin
      rvalid_q <= 1'b0;
      arready_q <= 1'b1;
    end else if (!rvalid_q) begin
      arready_q <= 1'b1;
    end
  end

  assign s_axi_awready = awready_q;
  assign s_axi_wready = wready_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_arready = arready_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rresp = rresp_q;
  assign s_axi_rdata = rdata_q;

endmodule

// File: sim/cpu16_core_assertions.sv
`timescale 1ns/1ps
// ******************
// Port checks.
// ******************
module cpu16_core_assertions (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input cpu16_pkg::cpu16_mem_req_s mem_req,
  input cpu16_pkg::cpu16_mem_rsp_s mem_rsp
);
  sequence s_both_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready &&
      !s_axi_bvalid;
  endsequence
  sequence s_first_fetch;
    mem_req.valid && !mem_req.write && mem_req.addr == cpu16_pkg::RESET_PC;
  endsequence
  chk_first_fetch: assert property (@(posedge aclk)
    disable iff (!aresetn) $rose(aresetn) |=> s_first_fetch)
    else $error("first fetch not at address zero");
  chk_reset_quiet: assert property (@(posedge aclk)
    !aresetn |=> !mem_req.valid && !s_axi_bvalid && !s_axi_rvalid)
    else $error("outputs active after reset edge");
  chk_mem_hold: assert property (@(posedge aclk)
    disable iff (!aresetn)
    mem_req.valid && !mem_rsp.ack |=> mem_req.valid && $stable(mem_req))
    else $error("memory request changed before ack");
  chk_access_gap: assert property (@(posedge aclk)
    disable iff (!aresetn)
    mem_req.valid && mem_req.write && mem_rsp.ack |=> !mem_req.valid)
    else $error("memory write held past its ack");
  chk_read_answer: assert property (@(posedge aclk)
    disable iff (!aresetn) s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  chk_read_refused: assert property (@(posedge aclk)
    disable iff (!aresetn) s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while answer pending");
  chk_rdata_hold: assert property (@(posedge aclk)
    disable iff (!aresetn) s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp))
    else $error("read answer dropped early");
  chk_bresp_hold: assert property (@(posedge aclk)
    disable iff (!aresetn) s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write answer dropped early");
  chk_write_answer: assert property (@(posedge aclk)
    disable iff (!aresetn) s_both_taken |-> ##2 s_axi_bvalid)
    else $error("write answer not two cycles after take");
  chk_unmapped_read: assert property (@(posedge aclk)
    disable iff (!aresetn)
    s_axi_arvalid && s_axi_arready && s_axi_araddr >= 8'h40 |=>
    s_axi_rresp == cpu16_pkg::RESP_SLVERR && s_axi_rdata == 32'h0)
    else $error("unmapped read not refused");
endmodule

// File: sim/cpu16_mem_model.sv
`timescale 1ns/1ps
// ******************
// Shared word memory.
// ******************
module cpu16_mem_model (
  input wire logic aclk,
  input wire logic aresetn,
  input cpu16_pkg::cpu16_mem_req_s mem_req,
  output cpu16_pkg::cpu16_mem_rsp_s mem_rsp
);
  logic [15:0] mem [65536];
  cpu16_pkg::cpu16_mem_rsp_s rsp_q = '0;
  logic [1:0] wait_q = 2'h0;
  assign mem_rsp = rsp_q;
  // Answers a held request after zero to two idle cycles.
  always @(posedge aclk) begin
    if (!aresetn || rsp_q.ack || !mem_req.valid) begin
      rsp_q.ack <= 1'b0;
      rsp_q.rdata <= ~rsp_q.rdata;
    end else if (wait_q != 2'h0) begin
      wait_q <= wait_q - 2'h1;
      rsp_q.rdata <= ~rsp_q.rdata;
    end else begin
      rsp_q.ack <= 1'b1;
      rsp_q.rdata <= mem[mem_req.addr];
      wait_q <= 2'($urandom % 3);
      if (mem_req.write) begin
        mem[mem_req.addr] <= mem_req.wdata;
      end
    end
  end
endmodule

// File: sim/sixteen_bit_cpu_decode_execute_test.sv
`timescale 1ns/1ps
// ******************
// Bench.
// ******************
module sixteen_bit_cpu_decode_execute_test;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'h0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  cpu16_pkg::cpu16_mem_req_s mem_req;
  cpu16_pkg::cpu16_mem_rsp_s mem_rsp;
  logic mf_pin = 1'b0, sf_pin = 1'b0, tk;
  logic [33:0] wr_q[$], rd_q[$];
  logic [1:0] b_q[$];
  logic [15:0] a, b, lit, lit2, m, t1, t2;
  int bad_count = 0, check_count = 0, rel;

  always #4 aclk = ~aclk;

  cpu16_core cpu16_core_inst (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .mem_req(mem_req), .mem_rsp(mem_rsp),
    .memory_flag_pin(mf_pin), .serial_port_flag_pin(sf_pin));
  cpu16_mem_model cpu16_mem_model_inst (.aclk(aclk), .aresetn(aresetn),
    .mem_req(mem_req), .mem_rsp(mem_rsp));

  task check(input logic [33:0] got, input logic [33:0] exp);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task check_resp(input logic [1:0] got, input logic [1:0] exp);
    check({32'h0, got}, {32'h0, exp});
  endtask
  task check_read(input logic [33:0] got, input logic [33:0] exp);
    check(got, exp);
  endtask

  task conclude;
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  function logic [15:0] ea(input int op, input int s, r1, r2, ro);
    return {3'(ro), 3'(r2), 3'(r1), 3'(s), 4'(op)};
  endfunction
  function logic [15:0] ei(input int op, input int s, rg, lv);
    return {8'(lv), 3'(rg), 1'(s), 4'(op)};
  endfunction
  task put(input int ad, input logic [15:0] w);
    cpu16_mem_model_inst.mem[16'(ad)] = w;
  endtask
  task put_ld(input int ad, input int rg, input int src);
    put(ad, ea(cpu16_pkg::OP_LOAD, 0, 0, 0, rg));
    put(ad + 1, 16'(src));
  endtask
  task put_st(input int ad, input int rg, input int dst);
    put(ad, ea(cpu16_pkg::OP_STORE, 0, 0, rg, 0));
    put(ad + 1, 16'(dst));
  endtask
  task put_loop(input int ad);
    put(ad, ea(cpu16_pkg::OP_JMP, cpu16_pkg::JMP_IMM, 0, 0, 0));
    put(ad + 1, 16'(ad));
  endtask
  task hold;
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
  endtask
  task drain;
    int k;
    k = 0;
    while (wr_q.size() != 0 && k < 3000) begin
      @(posedge aclk);
      k++;
    end
    check(34'(wr_q.size()), 34'h0);
    repeat (20) @(posedge aclk);
  endtask

  task axi_wr(input logic [7:0] ad, input logic [31:0] d,
    input logic [1:0] er);
    b_q.push_back(er);
    @(posedge aclk);
    s_axi_awaddr <= ad;
    s_axi_wdata <= d;
    s_axi_wstrb <= 4'hf;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
  endtask
  task axi_rd(input logic [7:0] ad, input logic [33:0] exp);
    rd_q.push_back(exp);
    @(posedge aclk);
    s_axi_araddr <= ad;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
  endtask

  // Compares each observed result with the oldest expectation.
  always @(posedge aclk) begin
    if (mem_req.valid && mem_req.write && mem_rsp.ack === 1'b1) begin
      check({2'h0, mem_req.addr, mem_req.wdata}, (wr_q.size() != 0) ?
        wr_q.pop_front() : 34'h3ffffffff);
    end
    if (s_axi_bvalid && s_axi_bready) begin
      check_resp(s_axi_bresp, b_q.pop_front());
    end
    if (s_axi_rvalid && s_axi_rready) begin
      check_read({s_axi_rresp, s_axi_rdata}, rd_q.pop_front());
    end
  end

  initial begin
    repeat (60000) @(posedge aclk);
    bad_count++;
    conclude();
  end

  initial begin
    void'($urandom(51));
    a = 16'($urandom);
    b = 16'($urandom);
    lit = 16'($urandom % 256);
    lit2 = 16'($urandom % 256);
    m = a[7:0] * b[7:0];
    t1 = ~(a & b) + lit;
    t2 = t1 * lit2;
    hold();
    put_ld(0, 1, 16'h0100);
    put_ld(2, 2, 16'h0101);
    for (int k = 0; k < 4; k++) begin
      put(4 + 3 * k, ea(cpu16_pkg::OP_ALU, k, 1, 2, 3));
      put_st(5 + 3 * k, 3, 16'h0200 + k);
    end
    put(16, ei(cpu16_pkg::OP_ALUI, 0, 3, lit));
    put_st(17, 3, 16'h0204);
    put(19, ei(cpu16_pkg::OP_ALUI, 1, 3, lit2));
    put_st(20, 3, 16'h0205);
    put_ld(22, 4, 16'h0102);
    put(24, ea(cpu16_pkg::OP_STORE, 1, 4, 1, 0));
    put(25, ea(cpu16_pkg::OP_LOAD, 1, 4, 0, 5));
    put_st(26, 5, 16'h0206);
    put_loop(28);
    put(16'h0100, a);
    put(16'h0101, b);
    put(16'h0102, 16'h0210);
    wr_q.push_back({2'h0, 16'h0200, a + b});
    wr_q.push_back({2'h0, 16'h0201, a - b});
    wr_q.push_back({2'h0, 16'h0202, m});
    wr_q.push_back({2'h0, 16'h0203, ~(a & b)});
    wr_q.push_back({2'h0, 16'h0204, t1});
    wr_q.push_back({2'h0, 16'h0205, t2});
    wr_q.push_back({2'h0, 16'h0210, a});
    wr_q.push_back({2'h0, 16'h0206, a});
    aresetn <= 1'b1;
    drain();
    axi_rd(8'h24, {18'h0, a});
    axi_rd(8'h2c, {18'h0, t2});
    axi_rd(8'h20, 34'h0);
    axi_rd(8'h80, {cpu16_pkg::RESP_SLVERR, 32'h0});
    axi_wr(8'h10, 32'h0, cpu16_pkg::RESP_SLVERR);
    axi_wr(cpu16_pkg::REG_CTRL, 32'h0, cpu16_pkg::RESP_OKAY);
    repeat (20) @(posedge aclk);
    axi_rd(cpu16_pkg::REG_PC, {18'h0, 16'h001c});
    axi_wr(cpu16_pkg::REG_CTRL, 32'h1, cpu16_pkg::RESP_OKAY);
    axi_rd(cpu16_pkg::REG_CTRL, {2'h0, 32'h1});
    for (int s = 0; s < 8; s++) begin
      a = 16'($urandom % 65533 + 1);
      rel = $urandom % 3;
      b = (rel == 0) ? a : (rel == 1) ? a - 16'h1 : a + 16'h1;
      mf_pin <= 1'($urandom);
      sf_pin <= 1'($urandom);
      hold();
      put_ld(0, 1, 16'h0100);
      put_ld(2, 2, 16'h0101);
      put(4, ea(cpu16_pkg::OP_ALU, cpu16_pkg::ALU_SUB, 1, 2, 3));
      put_ld(5, 6, 16'h0102);
      put(7, ea(cpu16_pkg::OP_JMP, s, 6, 0, 5));
      put(8, 16'h0040);
      put_st(9, 5, 16'h0201);
      put_loop(11);
      put_st(16'h0040, 5, 16'h0200);
      put_loop(16'h0042);
      put(16'h0100, a);
      put(16'h0101, b);
      put(16'h0102, 16'h0040);
      case (s)
        0, 6: tk = 1'b1;
        1, 7: tk = (a == b);
        2: tk = (a > b);
        3: tk = !(a > b);
        4: tk = mf_pin;
        default: tk = sf_pin;
      endcase
      wr_q.push_back({2'h0, tk ? 16'h0200 : 16'h0201,
        (s == 0 || s == 6) ? 16'h0 : 16'h7});
      aresetn <= 1'b1;
      drain();
    end
    conclude();
  end
endmodule

bind cpu16_core cpu16_core_assertions cpu16_core_assertions_inst (
  .aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
  .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .mem_req(mem_req), .mem_rsp(mem_rsp));
